// >>> src/qup_map.svh
`ifndef QUP_MAP_SVH
`define QUP_MAP_SVH
// clocks and rates
`define QUP_OSC_HZ        80000000
`define QUP_CLK_HZ        20000000
`define QUP_TICKS_PER_CLK (`QUP_OSC_HZ / `QUP_CLK_HZ)
`define QUP_RATE_MIN      300
`define QUP_RATE_MAX      2000000
`define QUP_RATE_RST      115200
`define QUP_DIV_RST       ((`QUP_OSC_HZ + `QUP_RATE_RST) / (2 * `QUP_RATE_RST) - 1)
// widths
`define QUP_NPORT         4
`define QUP_DIV_W         18
`define QUP_ACC_W         20
`define QUP_RATE_W        21
`define QUP_NUM_W         27
`define QUP_IT_W          5
`define QUP_LVL_W         12
`define QUP_EVT_W         4
// receive buffer
`define QUP_RX_DEPTH      2048
`define QUP_RX_AW         11
`define QUP_RTS_MARK      12'h600
// frame timing in half-bit ticks
`define QUP_HALF_BIT      3'h2
`define QUP_HALF_STOP1    3'h2
`define QUP_HALF_STOP15   3'h3
`define QUP_HALF_STOP2    3'h4
`define QUP_MIN_DBITS     4'h5
// bus decode: haddr[7:2] is {global, port[1:0], index[2:0]}
`define QUP_A_HI          7
`define QUP_A_LO          2
`define QUP_R_CFG         3'h0
`define QUP_R_RATE        3'h1
`define QUP_R_DIV         3'h2
`define QUP_R_TXD         3'h3
`define QUP_R_RXD         3'h4
`define QUP_R_CTRL        3'h5
`define QUP_R_STAT        3'h6
`define QUP_G_ISTAT       3'h0
`define QUP_G_IMASK       3'h1
`endif

// >>> src/qup_pkg.sv
`include "qup_map.svh"
package qup_pkg;
  typedef enum logic [2:0] {QUP_PAR_NONE, QUP_PAR_ODD, QUP_PAR_EVEN,
                            QUP_PAR_MARK, QUP_PAR_SET} qup_par_t;
  typedef enum logic [1:0] {QUP_STOP_1, QUP_STOP_15, QUP_STOP_2} qup_stop_t;
  typedef struct packed {
    logic      flow_en;
    qup_stop_t stop;
    qup_par_t  par;
    logic [1:0] dbits;
  } qup_cfg_t;
  typedef struct packed {logic dtr; logic brk;} qup_ctrl_t;
  typedef struct packed {logic ovr; logic brk; logic par; logic frm;} qup_evt_t;
  typedef struct packed {logic glb; logic [1:0] port; logic [2:0] idx;} qup_addr_t;
  typedef struct packed {
    logic [3:0]            rsv_hi;
    logic [`QUP_LVL_W-1:0] rx_level;
    logic [7:0]            rsv_lo;
    logic ri;
    logic dcd;
    logic dsr;
    logic cts;
    logic calc_busy;
    logic rx_avail;
    logic tx_busy;
    logic hold_full;
  } qup_stat_t;

  // one core clock of the half-bit timer: {tick, next accumulator}
  function automatic logic [`QUP_ACC_W:0] qup_step(input logic [`QUP_ACC_W-1:0] acc,
                                                   input logic [`QUP_DIV_W-1:0] div);
    logic [`QUP_ACC_W-1:0] s;
    s = acc + `QUP_ACC_W'(`QUP_TICKS_PER_CLK);
    if (s >= `QUP_ACC_W'(div)) return {1'b1, s - `QUP_ACC_W'(div)};
    return {1'b0, s};
  endfunction

  function automatic logic [3:0] qup_nbits(input logic [1:0] dbits);
    return `QUP_MIN_DBITS + {2'b00, dbits};
  endfunction

  function automatic logic [2:0] qup_stop_half(input qup_stop_t s);
    case (s)
      QUP_STOP_15: return `QUP_HALF_STOP15;
      QUP_STOP_2:  return `QUP_HALF_STOP2;
      default:     return `QUP_HALF_STOP1;
    endcase
  endfunction

  // parity bit over the low nb bits of d
  function automatic logic qup_par_bit(input qup_par_t p, input logic [7:0] d,
                                       input logic [3:0] nb);
    logic [7:0] m;
    m = d & (8'hFF >> (4'h8 - nb));
    case (p)
      QUP_PAR_ODD:  return ~^m;
      QUP_PAR_EVEN: return ^m;
      QUP_PAR_MARK: return 1'b1;
      default:      return 1'b0;
    endcase
  endfunction
endpackage

// >>> src/qup_tx.sv
`timescale 1ns/100ps
`default_nettype none
`include "qup_map.svh"
module qup_tx (
  input  wire logic                  clk_i,       // core clock
  input  wire logic                  sys_rst_i,   // sync reset
  input  wire qup_pkg::qup_cfg_t     cfg_i,       // frame format
  input  wire logic [`QUP_DIV_W-1:0] div_i,       // half-bit divider
  input  wire logic [7:0]            data_i,      // byte to send
  input  wire logic                  load_i,      // write holding reg
  input  wire logic                  brk_i,       // hold line low
  input  wire logic                  cts_n_i,     // remote clear to send
  output logic                       txd_o,       // serial out
  output logic                       hold_full_o, // holding reg busy
  output logic                       busy_o       // frame in flight
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} qup_tx_st_t;
  qup_tx_st_t            st_r, st_nxt;
  logic [`QUP_ACC_W-1:0] acc_r, acc_nxt, acc_s;
  logic                  tick, line;
  logic [2:0]            cnt_r, cnt_nxt, lim;
  logic [3:0]            bitn_r, bitn_nxt, nb;
  logic [7:0]            shf_r, shf_nxt, hold_r, hold_nxt;
  logic                  full_r, full_nxt, par_r, par_nxt, txd_r, txd_nxt;

  // frame sequencer and holding register
  always_comb begin
    {tick, acc_s} = qup_pkg::qup_step(acc_r, div_i);
    nb = qup_pkg::qup_nbits(cfg_i.dbits);
    lim = (st_r == TX_STOP) ? qup_pkg::qup_stop_half(cfg_i.stop) : `QUP_HALF_BIT;
    st_nxt = st_r; acc_nxt = acc_r; cnt_nxt = cnt_r; bitn_nxt = bitn_r;
    shf_nxt = shf_r; hold_nxt = hold_r; full_nxt = full_r; par_nxt = par_r;
    if (st_r == TX_IDLE) begin
      acc_nxt = '0;
      if (full_r && !(cfg_i.flow_en && cts_n_i)) begin
        shf_nxt = hold_r;
        par_nxt = qup_pkg::qup_par_bit(cfg_i.par, hold_r, nb);
        full_nxt = 1'b0;
        st_nxt = TX_START;
        cnt_nxt = '0;
        bitn_nxt = '0;
      end
    end else begin
      acc_nxt = acc_s;
      if (tick) begin
        if (cnt_r == lim - 3'h1) begin
          cnt_nxt = '0;
          unique case (st_r)
            TX_START: st_nxt = TX_DATA;
            TX_DATA: begin
              shf_nxt = shf_r >> 1;
              bitn_nxt = bitn_r + 4'h1;
              if (bitn_r == nb - 4'h1)
                st_nxt = (cfg_i.par == qup_pkg::QUP_PAR_NONE) ? TX_STOP : TX_PAR;
            end
            TX_PAR:  st_nxt = TX_STOP;
            TX_STOP: st_nxt = TX_IDLE;
            TX_IDLE: st_nxt = TX_IDLE;
          endcase
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
    end
    if (load_i && !full_r) begin
      hold_nxt = data_i;
      full_nxt = 1'b1;
    end
    unique case (st_r)
      TX_START: line = 1'b0;
      TX_DATA:  line = shf_r[0];
      TX_PAR:   line = par_r;
      default:  line = 1'b1;
    endcase
    txd_nxt = brk_i ? 1'b0 : line;
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= TX_IDLE; acc_r <= '0; cnt_r <= '0; bitn_r <= '0; shf_r <= '0;
      hold_r <= '0; full_r <= 1'b0; par_r <= 1'b0; txd_r <= 1'b1;
    end else begin
      st_r <= st_nxt; acc_r <= acc_nxt; cnt_r <= cnt_nxt; bitn_r <= bitn_nxt;
      shf_r <= shf_nxt; hold_r <= hold_nxt; full_r <= full_nxt; par_r <= par_nxt;
      txd_r <= txd_nxt;
    end
  end

  assign txd_o = txd_r;
  assign hold_full_o = full_r;
  assign busy_o = (st_r != TX_IDLE);
endmodule
`default_nettype wire

// >>> src/qup_rx.sv
`timescale 1ns/100ps
`default_nettype none
`include "qup_map.svh"
module qup_rx (
  input  wire logic                  clk_i,     // core clock
  input  wire logic                  sys_rst_i, // sync reset
  input  wire qup_pkg::qup_cfg_t     cfg_i,     // frame format
  input  wire logic [`QUP_DIV_W-1:0] div_i,     // half-bit divider
  input  wire logic                  rxd_i,     // serial in
  input  wire logic                  pop_i,     // take head byte
  output logic [7:0]                 data_o,    // head byte
  output logic [`QUP_LVL_W-1:0]      level_o,   // bytes held
  output qup_pkg::qup_evt_t          evt_o      // event pulses
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} qup_rx_st_t;
  logic [7:0]              mem [`QUP_RX_DEPTH];
  qup_rx_st_t              st_r, st_nxt;
  logic [`QUP_ACC_W-1:0]   acc_r, acc_nxt, acc_s, bacc_r, bacc_nxt;
  logic                    tick, btick, cnt_r, cnt_nxt, perr_r, perr_nxt, push, pop;
  logic [3:0]              bitn_r, bitn_nxt, nb;
  logic [4:0]              lcnt_r, lcnt_nxt, ch;
  logic [7:0]              shf_r, shf_nxt, aligned;
  logic [`QUP_RX_AW-1:0]   wp_r, wp_nxt, rp_r, rp_nxt;
  logic [`QUP_LVL_W-1:0]   lvl_r, lvl_nxt;
  qup_pkg::qup_evt_t       evt_r, evt_nxt;

  // centre sampling, break watch and buffer pointers
  always_comb begin
    {tick, acc_s} = qup_pkg::qup_step(acc_r, div_i);
    {btick, bacc_nxt} = qup_pkg::qup_step(bacc_r, div_i);
    nb = qup_pkg::qup_nbits(cfg_i.dbits);
    aligned = shf_r >> (4'h8 - nb);
    ch = {nb + 4'h1 + {3'h0, cfg_i.par != qup_pkg::QUP_PAR_NONE}, 1'b0}
         + {2'h0, qup_pkg::qup_stop_half(cfg_i.stop)};
    st_nxt = st_r; acc_nxt = acc_s; cnt_nxt = cnt_r; bitn_nxt = bitn_r;
    shf_nxt = shf_r; perr_nxt = perr_r; evt_nxt = '0; push = 1'b0;
    unique case (st_r)
      RX_IDLE: begin
        acc_nxt = '0;
        if (!rxd_i) begin
          st_nxt = RX_START; cnt_nxt = 1'b0; bitn_nxt = '0; perr_nxt = 1'b0;
        end
      end
      RX_START: if (tick) st_nxt = rxd_i ? RX_IDLE : RX_DATA;
      default: if (tick) begin
        cnt_nxt = ~cnt_r;
        if (cnt_r) begin
          if (st_r == RX_DATA) begin
            shf_nxt = {rxd_i, shf_r[7:1]};
            bitn_nxt = bitn_r + 4'h1;
            if (bitn_r == nb - 4'h1)
              st_nxt = (cfg_i.par == qup_pkg::QUP_PAR_NONE) ? RX_STOP : RX_PAR;
          end else if (st_r == RX_PAR) begin
            perr_nxt = rxd_i != qup_pkg::qup_par_bit(cfg_i.par, aligned, nb);
            st_nxt = RX_STOP;
          end else begin
            evt_nxt.frm = !rxd_i;
            evt_nxt.par = perr_r;
            push = (lvl_r != `QUP_LVL_W'(`QUP_RX_DEPTH));
            evt_nxt.ovr = !push;
            st_nxt = RX_IDLE;
          end
        end
      end
    endcase
    if (rxd_i) lcnt_nxt = '0;
    else if (btick && lcnt_r != '1) lcnt_nxt = lcnt_r + 5'h1;
    else lcnt_nxt = lcnt_r;
    evt_nxt.brk = btick && !rxd_i && (lcnt_r == ch);
    pop = pop_i && (lvl_r != '0);
    wp_nxt = wp_r + `QUP_RX_AW'(push);
    rp_nxt = rp_r + `QUP_RX_AW'(pop);
    lvl_nxt = lvl_r + `QUP_LVL_W'(push) - `QUP_LVL_W'(pop);
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r <= RX_IDLE; acc_r <= '0; bacc_r <= '0; cnt_r <= 1'b0; bitn_r <= '0;
      shf_r <= '0; perr_r <= 1'b0; lcnt_r <= '0; wp_r <= '0; rp_r <= '0;
      lvl_r <= '0; evt_r <= '0;
    end else begin
      st_r <= st_nxt; acc_r <= acc_nxt; bacc_r <= bacc_nxt; cnt_r <= cnt_nxt;
      bitn_r <= bitn_nxt; shf_r <= shf_nxt; perr_r <= perr_nxt; lcnt_r <= lcnt_nxt;
      wp_r <= wp_nxt; rp_r <= rp_nxt; lvl_r <= lvl_nxt; evt_r <= evt_nxt;
    end
  end

  // receive buffer storage
  always_ff @(posedge clk_i) begin
    if (push) mem[wp_r] <= aligned;
  end

  assign data_o = mem[rp_r];
  assign level_o = lvl_r;
  assign evt_o = evt_r;
endmodule
`default_nettype wire

// >>> src/qup_core.sv
`timescale 1ns/100ps
`default_nettype none
`include "qup_map.svh"
// Behaviour
// - four independent ports, each with data, request/clear-to-send and modem lines.
// - frames carry 5 to 8 data bits and 1, 1.5 or 2 stop bits as configured.
// - parity is odd, even, set, mark or absent.
// - any requested rate from 300 bit/s to 2 Mbit/s is taken, rates outside are clamped to that range.
// - divider is the 80 MHz oscillator over twice the rate, rounded, minus one.
// - the rate produced is the 80 MHz oscillator over twice the divider.
// - a receive line low for longer than one character time reports a break.
// - a break command holds the transmit line low until the break is cleared.
// - with flow control the request output stays low below 1536 buffered bytes.
// - with flow control at most one more byte goes out after clear-to-send goes high.
module qup_core (
  input  wire logic                  clk_i,       // core clock
  input  wire logic                  sys_rst_i,   // sync reset, active high
  input  wire logic                  hsel_i,      // slave select
  input  wire logic [31:0]           haddr_i,     // byte address
  input  wire logic [1:0]            htrans_i,    // transfer type
  input  wire logic                  hwrite_i,    // write when high
  input  wire logic [2:0]            hsize_i,     // word transfers only
  input  wire logic [31:0]           hwdata_i,    // write data
  input  wire logic                  hready_i,    // bus ready
  output logic [31:0]                hrdata_o,    // read data
  output logic                       hreadyout_o, // always ready
  output logic                       hresp_o,     // always okay
  output logic [`QUP_NPORT-1:0]      txd_o,       // serial out
  input  wire logic [`QUP_NPORT-1:0] rxd_i,       // serial in
  output logic [`QUP_NPORT-1:0]      rts_n_o,     // request to send
  input  wire logic [`QUP_NPORT-1:0] cts_n_i,     // clear to send
  output logic [`QUP_NPORT-1:0]      dtr_n_o,     // terminal ready
  input  wire logic [`QUP_NPORT-1:0] dsr_n_i,     // set ready
  input  wire logic [`QUP_NPORT-1:0] dcd_n_i,     // carrier detect
  input  wire logic [`QUP_NPORT-1:0] ri_n_i,      // ring indicator
  output logic                       irq_o        // interrupt level
);
  localparam int NP = `QUP_NPORT;
  localparam int IW = `QUP_NPORT * `QUP_EVT_W;

  // per-port host registers
  qup_pkg::qup_cfg_t      cfg_r [NP];
  qup_pkg::qup_cfg_t      cfg_nxt [NP];
  logic [`QUP_RATE_W-1:0] rate_r [NP];
  logic [`QUP_RATE_W-1:0] rate_nxt [NP];
  logic [`QUP_DIV_W-1:0]  div_r [NP];
  logic [`QUP_DIV_W-1:0]  div_nxt [NP];
  qup_pkg::qup_ctrl_t     ctrl_r [NP];
  qup_pkg::qup_ctrl_t     ctrl_nxt [NP];
  logic [NP-1:0]          pend_r, pend_nxt, set_pend, clr_pend, load;
  logic [NP-1:0]          pop, full_w, busy_w;
  logic [7:0]             rxdat_w [NP];
  logic [`QUP_LVL_W-1:0]  lvl_w [NP];
  qup_pkg::qup_evt_t      evt_w [NP];

  // interrupt registers
  logic [IW-1:0]          ist_r, ist_nxt, mask_r, mask_nxt, w1c, ev_flat;
  logic                   irq_r, irq_nxt;

  // bus slave registers
  logic                   wp_r, wp_nxt;
  qup_pkg::qup_addr_t     wa_r, wa_nxt, ra;
  logic [31:0]            hrdata_r, hrdata_nxt, rq;
  logic                   hreadyout_r, hresp_r;
  logic [NP-1:0]          rts_n_r, rts_n_nxt, dtr_n_r, dtr_n_nxt;
  qup_pkg::qup_stat_t     stat;
  logic [7:0]             txdat;

  // divider calculator
  logic                   busy_r, busy_nxt, qb;
  logic [1:0]             cport_r, cport_nxt;
  logic [`QUP_NUM_W-1:0]  num_r, num_nxt, quo_r, quo_nxt;
  logic [`QUP_RATE_W:0]   rem_r, rem_nxt, den;
  logic [`QUP_RATE_W+1:0] r2;
  logic [`QUP_IT_W-1:0]   it_r, it_nxt;

  // lowest pending port
  function automatic logic [1:0] first_set(input logic [NP-1:0] v);
    logic [1:0] k;
    k = '0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (v[i]) k = 2'(i);
    end
    return k;
  endfunction

  // one transmitter and one receiver per port
  for (genvar p = 0; p < NP; p++) begin : g_port
    qup_tx u_tx (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .cfg_i       (cfg_r[p]),
      .div_i       (div_r[p]),
      .data_i      (txdat),
      .load_i      (load[p]),
      .brk_i       (ctrl_r[p].brk),
      .cts_n_i     (cts_n_i[p]),
      .txd_o       (txd_o[p]),
      .hold_full_o (full_w[p]),
      .busy_o      (busy_w[p])
    );
    qup_rx u_rx (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .cfg_i     (cfg_r[p]),
      .div_i     (div_r[p]),
      .rxd_i     (rxd_i[p]),
      .pop_i     (pop[p]),
      .data_o    (rxdat_w[p]),
      .level_o   (lvl_w[p]),
      .evt_o     (evt_w[p])
    );
  end

  // register file: address phase reads, data phase writes
  always_comb begin
    ra = qup_pkg::qup_addr_t'(haddr_i[`QUP_A_HI:`QUP_A_LO]);
    hrdata_nxt = hrdata_r;
    wp_nxt = 1'b0;
    wa_nxt = wa_r;
    mask_nxt = mask_r;
    w1c = '0;
    set_pend = '0;
    load = '0;
    pop = '0;
    txdat = hwdata_i[7:0];
    rq = hwdata_i;
    stat = '0;
    for (int p = 0; p < NP; p++) begin
      cfg_nxt[p] = cfg_r[p];
      rate_nxt[p] = rate_r[p];
      ctrl_nxt[p] = ctrl_r[p];
    end
    if (wp_r) begin
      if (wa_r.glb) begin
        if (wa_r.idx == `QUP_G_ISTAT) w1c = hwdata_i[IW-1:0];
        if (wa_r.idx == `QUP_G_IMASK) mask_nxt = hwdata_i[IW-1:0];
      end else begin
        unique case (wa_r.idx)
          `QUP_R_CFG: cfg_nxt[wa_r.port] = qup_pkg::qup_cfg_t'(hwdata_i[7:0]);
          `QUP_R_RATE: begin
            if (hwdata_i < `QUP_RATE_MIN) rq = `QUP_RATE_MIN;
            else if (hwdata_i > `QUP_RATE_MAX) rq = `QUP_RATE_MAX;
            rate_nxt[wa_r.port] = rq[`QUP_RATE_W-1:0];
            set_pend[wa_r.port] = 1'b1;
          end
          `QUP_R_TXD:  load[wa_r.port] = 1'b1;
          `QUP_R_CTRL: ctrl_nxt[wa_r.port] = qup_pkg::qup_ctrl_t'(hwdata_i[1:0]);
          default: ;
        endcase
      end
    end
    if (hsel_i && htrans_i[1] && hready_i) begin
      wp_nxt = hwrite_i;
      wa_nxt = ra;
      if (!hwrite_i) begin
        hrdata_nxt = '0;
        stat.hold_full = full_w[ra.port];
        stat.tx_busy = busy_w[ra.port];
        stat.rx_avail = (lvl_w[ra.port] != '0);
        stat.calc_busy = pend_r[ra.port] || (busy_r && cport_r == ra.port);
        stat.cts = ~cts_n_i[ra.port];
        stat.dsr = ~dsr_n_i[ra.port];
        stat.dcd = ~dcd_n_i[ra.port];
        stat.ri = ~ri_n_i[ra.port];
        stat.rx_level = lvl_w[ra.port];
        if (ra.glb) begin
          if (ra.idx == `QUP_G_ISTAT) hrdata_nxt = 32'(ist_r);
          if (ra.idx == `QUP_G_IMASK) hrdata_nxt = 32'(mask_r);
        end else begin
          unique case (ra.idx)
            `QUP_R_CFG:  hrdata_nxt = 32'(cfg_r[ra.port]);
            `QUP_R_RATE: hrdata_nxt = 32'(rate_r[ra.port]);
            `QUP_R_DIV:  hrdata_nxt = 32'(div_r[ra.port]);
            `QUP_R_RXD: begin
              hrdata_nxt = 32'(rxdat_w[ra.port]);
              pop[ra.port] = 1'b1;
            end
            `QUP_R_CTRL: hrdata_nxt = 32'(ctrl_r[ra.port]);
            `QUP_R_STAT: hrdata_nxt = stat;
            default:     hrdata_nxt = '0;
          endcase
        end
      end
    end
  end

  // interrupt status, mask and pin levels
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      ev_flat[p*`QUP_EVT_W +: `QUP_EVT_W] = evt_w[p];
      rts_n_nxt[p] = cfg_r[p].flow_en && (lvl_w[p] >= `QUP_RTS_MARK);
      dtr_n_nxt[p] = ~ctrl_r[p].dtr;
    end
    ist_nxt = (ist_r & ~w1c) | ev_flat;
    irq_nxt = |(ist_r & mask_r);
  end

  // rounded divider by restoring division
  always_comb begin
    busy_nxt = busy_r;
    cport_nxt = cport_r;
    num_nxt = num_r;
    quo_nxt = quo_r;
    rem_nxt = rem_r;
    it_nxt = it_r;
    clr_pend = '0;
    for (int p = 0; p < NP; p++) div_nxt[p] = div_r[p];
    den = {rate_r[cport_r], 1'b0};
    r2 = {rem_r, num_r[`QUP_NUM_W-1]};
    qb = (r2 >= {1'b0, den});
    if (!busy_r) begin
      if (pend_r != '0) begin
        cport_nxt = first_set(pend_r);
        clr_pend[cport_nxt] = 1'b1;
        // oscillator plus rate over twice the rate rounds to nearest
        num_nxt = `QUP_NUM_W'(`QUP_OSC_HZ) + `QUP_NUM_W'(rate_r[cport_nxt]);
        quo_nxt = '0;
        rem_nxt = '0;
        it_nxt = `QUP_IT_W'(`QUP_NUM_W);
        busy_nxt = 1'b1;
      end
    end else begin
      // full width: twice the top rate overflows the rate field
      rem_nxt = qb ? (`QUP_RATE_W+1)'(r2 - {1'b0, den}) : r2[`QUP_RATE_W:0];
      num_nxt = num_r << 1;
      quo_nxt = {quo_r[`QUP_NUM_W-2:0], qb};
      it_nxt = it_r - `QUP_IT_W'(1);
      if (it_r == `QUP_IT_W'(1)) begin
        busy_nxt = 1'b0;
        div_nxt[cport_r] = quo_nxt[`QUP_DIV_W-1:0] - `QUP_DIV_W'(1);
      end
    end
    pend_nxt = (pend_r & ~clr_pend) | set_pend;
  end

  // all state registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int p = 0; p < NP; p++) begin
        cfg_r[p] <= '0;
        rate_r[p] <= `QUP_RATE_W'(`QUP_RATE_RST);
        div_r[p] <= `QUP_DIV_W'(`QUP_DIV_RST);
        ctrl_r[p] <= '0;
      end
      pend_r <= '0;
      // calculator idle, interrupts off
      busy_r <= 1'b0;
      cport_r <= '0;
      num_r <= '0;
      quo_r <= '0;
      rem_r <= '0;
      it_r <= '0;
      ist_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
      wp_r <= 1'b0;
      wa_r <= '0;
      hrdata_r <= '0;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      rts_n_r <= '0;
      dtr_n_r <= '1;
    end else begin
      for (int p = 0; p < NP; p++) begin
        cfg_r[p] <= cfg_nxt[p];
        rate_r[p] <= rate_nxt[p];
        div_r[p] <= div_nxt[p];
        ctrl_r[p] <= ctrl_nxt[p];
      end
      pend_r <= pend_nxt;
      // calculator, interrupt and bus state
      busy_r <= busy_nxt;
      cport_r <= cport_nxt;
      num_r <= num_nxt;
      quo_r <= quo_nxt;
      rem_r <= rem_nxt;
      it_r <= it_nxt;
      ist_r <= ist_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      wp_r <= wp_nxt;
      wa_r <= wa_nxt;
      hrdata_r <= hrdata_nxt;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      rts_n_r <= rts_n_nxt;
      dtr_n_r <= dtr_n_nxt;
    end
  end

  assign hrdata_o = hrdata_r;
  assign hreadyout_o = hreadyout_r;
  assign hresp_o = hresp_r;
  assign rts_n_o = rts_n_r;
  assign dtr_n_o = dtr_n_r;
  assign irq_o = irq_r;
endmodule
`default_nettype wire

// >>> test/qup_core_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module qup_core_monitor (
  input wire logic        clk_i,     // clock
  input wire logic        sys_rst_i, // reset
  input wire logic        hsel_i,    // select
  input wire logic [31:0] haddr_i,   // address
  input wire logic [1:0]  htrans_i,  // transfer
  input wire logic        hwrite_i,  // write
  input wire logic [31:0] hwdata_i,  // wdata
  input wire logic        hready_i,  // ready
  input wire logic [31:0] hrdata_o,  // rdata
  input wire logic [3:0]  txd_o,     // serial out
  input wire logic [3:0]  rts_n_o,   // request
  input wire logic [3:0]  dtr_n_o,   // terminal
  input wire logic        irq_o      // interrupt
);
  // transfers carried into their data phase
  logic       wr_r;  // write data phase
  logic       rd_r;  // read data phase
  logic       brk_r; // port 0 break state
  logic [7:0] adr_r; // offset
  always_ff @(posedge clk_i) begin
    wr_r  <= !sys_rst_i & hsel_i & htrans_i[1] & hready_i & hwrite_i;
    rd_r  <= !sys_rst_i & hsel_i & htrans_i[1] & hready_i & !hwrite_i;
    adr_r <= haddr_i[7:0];
    brk_r <= sys_rst_i ? 1'b0 : (wr_r && adr_r == 8'h14) ? hwdata_i[0] : brk_r;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_txd_idle: assert property ($past(sys_rst_i) |-> txd_o == 4'hF)
    else $error("txd low after reset");
  a_rts_open: assert property ($past(sys_rst_i) |-> rts_n_o == 4'h0)
    else $error("rts high after reset");
  a_dtr_rst: assert property ($past(sys_rst_i) |-> dtr_n_o == 4'hF && !irq_o)
    else $error("dtr or irq after reset");
  a_dtr_follow: assert property (wr_r && adr_r == 8'h14 && hwdata_i[1] |-> ##[1:2] !dtr_n_o[0])
    else $error("dtr not asserted");
  a_break_low: assert property (wr_r && adr_r == 8'h14 && hwdata_i[0] |-> ##[1:3] !txd_o[0])
    else $error("break not driven");
  a_break_hold: assert property (brk_r && $past(brk_r, 2) |-> !txd_o[0])
    else $error("break released");
  a_unmapped_zero: assert property (rd_r && adr_r[4:2] == 3'h7 && !adr_r[7] |-> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_mask_off: assert property (wr_r && adr_r == 8'h84 && hwdata_i == 32'h0 |-> ##2 !irq_o [*3])
    else $error("irq while masked");
endmodule
bind qup_core qup_core_monitor u_mon (.clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i,
  .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .txd_o, .rts_n_o, .dtr_n_o, .irq_o);
`default_nettype wire

// >>> test/qup_peer.sv
`timescale 1ns/100ps
`default_nettype none
module qup_peer #(
  parameter real BIT = 975.0 // bit time in ns, device rate exactly
) (
  input  wire logic txd_i,  // device serial out
  output logic      rxd_o,  // device serial in
  output logic      cts_n_o // clear to send
);
  // line idles high, flow open
  initial begin
    rxd_o = 1'b1;
    cts_n_o = 1'b0;
  end
  // start, data lsb first, parity, stop
  task automatic send(input logic [9:0] f);
    rxd_o <= 1'b0;
    #(BIT);
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      #(BIT);
    end
    rxd_o <= 1'b1;
  endtask
  // line held low well past one character
  task automatic brk();
    rxd_o <= 1'b0;
    #(BIT * 30);
    rxd_o <= 1'b1;
  endtask
  // clear to send level
  task automatic flow(input logic v);
    cts_n_o <= v;
  endtask
  // sample a frame at bit centres
  task automatic get(output logic [9:0] f);
    @(negedge txd_i);
    #(BIT * 1.5);
    for (int i = 0; i < 10; i++) begin
      f[i] = txd_i;
      #(BIT);
    end
  endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, v) begin tests_run++; if ((v) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, v); end end
module tb;
  logic        clk_i, sys_rst_i, hsel_i, hwrite_i, rxd, cts_n, hreadyout_o, hresp_o, irq_o;
  logic [1:0]  htrans_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, q;
  logic [9:0]  f;
  logic [3:0]  txd_o, rts_n_o, dtr_n_o;
  int          n_errors = 0, tests_run = 0, cyc = 0;
  // device with port 0 on the peer
  qup_core u_dut (.clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
    .hresp_o, .txd_o, .rxd_i({3'h7, rxd}), .rts_n_o, .cts_n_i({3'h0, cts_n}),
    .dtr_n_o, .dsr_n_i(4'hE), .dcd_n_i(4'hF), .ri_n_i(4'hF), .irq_o);
  qup_peer u_peer (.txd_i(txd_o[0]), .rxd_o(rxd), .cts_n_o(cts_n));
  // clock and run limit
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one single word transfer, read data into q
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i); // start after an edge
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask
  // request a rate, wait for the divider, compare it
  task automatic calc(input logic [31:0] r, input logic [31:0] e);
    int i;
    i = 0;
    bus(1'b1, 32'h4, r);
    do begin
      bus(1'b0, 32'h18, 32'h0);
      i++;
    end while (q[3] !== 1'b0 && i < 50);
    bus(1'b0, 32'h8, 32'h0);
    `CHK("divider", e, q)
  endtask
  // main sequence
  initial begin
    sys_rst_i = 1'b1;
    {hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(1'b0, 32'h8, 32'h0);
    `CHK("div reset", 32'h15A, q)
    calc(32'h64, 32'h208D4);
    calc(32'h2DC6C0, 32'h13);
    calc(32'hF4240, 32'h27);
    bus(1'b1, 32'h0, 32'hB);
    bus(1'b1, 32'h14, 32'h2);
    bus(1'b0, 32'h18, 32'h0);
    `CHK("dsr", 1'b1, q[5])
    `CHK("dtr", 4'hE, dtr_n_o)
    fork
      u_peer.get(f);
      bus(1'b1, 32'hC, 32'hA7);
    join
    `CHK("tx frame", 10'h3A7, f)
    u_peer.send({1'b1, ^8'h3C, 8'h3C});
    bus(1'b0, 32'h18, 32'h0);
    `CHK("rx level", 12'h1, q[27:16])
    bus(1'b0, 32'h10, 32'h0);
    `CHK("rx byte", 32'h3C, q)
    bus(1'b1, 32'h84, 32'h5);
    u_peer.send(10'h055);
    repeat (4) @(posedge clk_i);
    `CHK("irq frame", 1'b1, irq_o)
    bus(1'b1, 32'h80, 32'hF);
    repeat (3) @(posedge clk_i);
    `CHK("irq clear", 1'b0, irq_o)
    u_peer.brk();
    bus(1'b0, 32'h80, 32'h0);
    `CHK("rx break", 1'b1, q[2])
    bus(1'b1, 32'h84, 32'h0);
    bus(1'b1, 32'h14, 32'h3);
    repeat (300) @(posedge clk_i);
    `CHK("break tx", 1'b0, txd_o[0])
    bus(1'b1, 32'h14, 32'h2);
    repeat (3) @(posedge clk_i);
    `CHK("break off", 1'b1, txd_o[0])
    bus(1'b0, 32'h1C, 32'h0);
    `CHK("unmapped", 32'h0, q)
    `CHK("okay", 1'b0, hresp_o)
    bus(1'b1, 32'h0, 32'h8B);
    `CHK("rts", 4'h0, rts_n_o)
    u_peer.flow(1'b1);
    bus(1'b1, 32'hC, 32'h11);
    repeat (300) @(posedge clk_i);
    `CHK("cts hold", 1'b1, txd_o[0])
    fork
      u_peer.get(f);
      u_peer.flow(1'b0);
    join
    `CHK("cts go", 10'h211, f)
    end_of_test();
  end
endmodule
`default_nettype wire
